// ---- core/smbus_status_errors.sv ----
`timescale 1ns/1ps
module smbus_status_errors
    import smbus_status_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic reg_unlocked,
    input wire logic [6:0] slave_port_addr,
    input wire logic [6:0] master_port_addr,
    input wire logic load_at_reset_mode,
    input wire logic load_finished,
    input wire logic load_error_stop,
    input wire logic checksum_mismatch,
    input wire logic no_config_done,
    input wire logic unmapped_load_write,
    input wire logic nack_seen,
    input wire logic misplaced_cond,
    input wire logic xact_start,
    input wire logic arb_won,
    input wire logic arb_lost,
    output logic arb_retry,
    output logic xact_abort,
    output logic [6:0] expander_addr,
    output logic skip_checksum_check,
    output logic ignore_rival_masters
);
    typedef struct packed
    {
        logic init_done;
        logic [6:0] slave_port_addr;
        logic [6:0] master_port_addr;
        logic [6:0] expander_addr;
        logic eeprom_load_done;
        logic nack_err;
        logic lost_arb_err;
        logic misplaced_cond_err;
        logic init_checksum_err;
        logic unmapped_load_err;
        logic skip_checksum_check;
        logic ignore_rival_masters;
        logic arb_retry;
        logic xact_abort;
        logic [31:0] rdata;
    } status_state_t;

    status_state_t st_r;
    status_state_t st_nxt;
    logic status_wr;
    logic control_wr;
    logic [31:0] status_word;
    logic [31:0] control_word;
    arb_event_if arb_ev ();

    ////////////////////////////////////////////////////////////////////////
    // Arbitration retry counter

    assign arb_ev.arb_lost = arb_lost;
    assign arb_ev.arb_won = arb_won;
    assign arb_ev.xact_start = xact_start;
    assign arb_ev.ignore_masters = st_r.ignore_rival_masters;

    arb_retry_counter u_arb (
        .mclk(mclk),
        .rst_n(rst_n),
        .ev(arb_ev.counter)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register map

    function automatic logic sticky(input logic cur, input logic set, input logic clr_wr, input logic clr_bit);
        // Set wins over clear
        sticky = set || (cur && !(clr_wr && clr_bit));
    endfunction : sticky

    assign status_wr = reg_wr && (reg_addr == STATUS_OFFSET);
    assign control_wr = reg_wr && (reg_addr == CONTROL_OFFSET);

    always_comb
    begin
        status_word = 32'h00000000;
        status_word[SLAVE_ADDR_LSB +: 7] = st_r.slave_port_addr;
        status_word[MASTER_ADDR_LSB +: 7] = st_r.master_port_addr;
        status_word[EXPANDER_ADDR_LSB +: 7] = st_r.expander_addr;
        status_word[LOAD_DONE_BIT] = st_r.eeprom_load_done;
        status_word[NACK_ERR_BIT] = st_r.nack_err;
        status_word[LOST_ARB_ERR_BIT] = st_r.lost_arb_err;
        status_word[MISPLACED_ERR_BIT] = st_r.misplaced_cond_err;
        status_word[CHECKSUM_ERR_BIT] = st_r.init_checksum_err;
        status_word[UNMAPPED_ERR_BIT] = st_r.unmapped_load_err;
        control_word = 32'h00000000;
        control_word[IGNORE_MASTERS_BIT] = st_r.ignore_rival_masters;
        control_word[SKIP_CHECKSUM_BIT] = st_r.skip_checksum_check;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        st_nxt = st_r;
        if (!rst_n)
        begin
            st_nxt = '0;
            st_nxt.expander_addr = EXPANDER_ADDR_RESET;
        end
        else
        begin
            st_nxt.init_done = 1'b1;
            if (!st_r.init_done)
            begin
                st_nxt.slave_port_addr = slave_port_addr;
                st_nxt.master_port_addr = master_port_addr;
            end
            if (status_wr && reg_unlocked)
            begin
                st_nxt.expander_addr = reg_wdata[EXPANDER_ADDR_LSB +: 7];
            end
            if (control_wr)
            begin
                st_nxt.ignore_rival_masters = reg_wdata[IGNORE_MASTERS_BIT];
                st_nxt.skip_checksum_check = reg_wdata[SKIP_CHECKSUM_BIT];
            end
            if (load_at_reset_mode && (load_finished || load_error_stop))
            begin
                st_nxt.eeprom_load_done = 1'b1;
            end
            st_nxt.nack_err = sticky(st_r.nack_err, nack_seen, status_wr, reg_wdata[NACK_ERR_BIT]);
            st_nxt.lost_arb_err = sticky(st_r.lost_arb_err, arb_ev.abort, status_wr,
                reg_wdata[LOST_ARB_ERR_BIT]);
            st_nxt.misplaced_cond_err = sticky(st_r.misplaced_cond_err, misplaced_cond, status_wr,
                reg_wdata[MISPLACED_ERR_BIT]);
            st_nxt.init_checksum_err = sticky(st_r.init_checksum_err,
                (checksum_mismatch && !st_r.skip_checksum_check) || no_config_done,
                status_wr, reg_wdata[CHECKSUM_ERR_BIT]);
            st_nxt.unmapped_load_err = sticky(st_r.unmapped_load_err, unmapped_load_write, status_wr,
                reg_wdata[UNMAPPED_ERR_BIT]);
            st_nxt.arb_retry = arb_ev.retry;
            st_nxt.xact_abort = arb_ev.abort;
            if (reg_rd && reg_addr == STATUS_OFFSET)
            begin
                st_nxt.rdata = status_word;
            end
            else if (reg_rd && reg_addr == CONTROL_OFFSET)
            begin
                st_nxt.rdata = control_word;
            end
            else
            begin
                st_nxt.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        st_r <= st_nxt;
    end

    assign reg_rdata = st_r.rdata;
    assign arb_retry = st_r.arb_retry;
    assign xact_abort = st_r.xact_abort;
    assign expander_addr = st_r.expander_addr;
    assign skip_checksum_check = st_r.skip_checksum_check;
    assign ignore_rival_masters = st_r.ignore_rival_masters;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_slave_addr_stable;
        @(posedge mclk) disable iff (!rst_n)
        st_r.init_done && $past(st_r.init_done) |-> $stable(st_r.slave_port_addr);
    endproperty
    a_slave_addr_stable: assert property (p_slave_addr_stable) else $error("slave address changed");

    property p_master_addr_stable;
        @(posedge mclk) disable iff (!rst_n)
        st_r.init_done && $past(st_r.init_done) |-> $stable(st_r.master_port_addr);
    endproperty
    a_master_addr_stable: assert property (p_master_addr_stable) else $error("master address changed");

    property p_expander_locked;
        @(posedge mclk) disable iff (!rst_n)
        !(status_wr && reg_unlocked) |=> $stable(expander_addr);
    endproperty
    a_expander_locked: assert property (p_expander_locked) else $error("expander address written while locked");

    property p_load_done;
        @(posedge mclk) disable iff (!rst_n)
        load_at_reset_mode && (load_finished || load_error_stop) |=> st_r.eeprom_load_done;
    endproperty
    a_load_done: assert property (p_load_done) else $error("load done not set");

    property p_nack_set_wins;
        @(posedge mclk) disable iff (!rst_n)
        nack_seen |=> st_r.nack_err;
    endproperty
    a_nack_set_wins: assert property (p_nack_set_wins) else $error("nack flag not set");

    property p_nack_clear;
        @(posedge mclk) disable iff (!rst_n)
        status_wr && reg_wdata[NACK_ERR_BIT] && !nack_seen |=> !st_r.nack_err;
    endproperty
    a_nack_clear: assert property (p_nack_clear) else $error("nack flag not cleared");

    property p_lost_arb_flag;
        @(posedge mclk) disable iff (!rst_n)
        arb_ev.abort |=> st_r.lost_arb_err && xact_abort;
    endproperty
    a_lost_arb_flag: assert property (p_lost_arb_flag) else $error("lost arbitration flag missing");

    property p_misplaced;
        @(posedge mclk) disable iff (!rst_n)
        misplaced_cond |=> st_r.misplaced_cond_err;
    endproperty
    a_misplaced: assert property (p_misplaced) else $error("misplaced condition flag missing");

    property p_checksum_skip;
        @(posedge mclk) disable iff (!rst_n)
        !st_r.init_checksum_err && st_r.skip_checksum_check && !no_config_done |=> !st_r.init_checksum_err;
    endproperty
    a_checksum_skip: assert property (p_checksum_skip) else $error("checksum error raised while skipped");

    property p_checksum_set;
        @(posedge mclk) disable iff (!rst_n)
        no_config_done |=> st_r.init_checksum_err;
    endproperty
    a_checksum_set: assert property (p_checksum_set) else $error("checksum flag missing");

    property p_unmapped;
        @(posedge mclk) disable iff (!rst_n)
        unmapped_load_write |=> st_r.unmapped_load_err;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped flag missing");

    property p_reserved_zero;
        @(posedge mclk) disable iff (!rst_n)
        $past(reg_rd && reg_addr == STATUS_OFFSET) |-> (reg_rdata & 32'hc0010101) == 32'h00000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
endmodule : smbus_status_errors

// ---- core/smbus_status_pkg.sv ----
package smbus_status_pkg;
    localparam logic [11:0] STATUS_OFFSET = 12'h0ac;
    localparam logic [11:0] CONTROL_OFFSET = 12'h0b0;
    localparam int SLAVE_ADDR_LSB = 1;
    localparam int MASTER_ADDR_LSB = 9;
    localparam int EXPANDER_ADDR_LSB = 17;
    localparam int LOAD_DONE_BIT = 24;
    localparam int NACK_ERR_BIT = 25;
    localparam int LOST_ARB_ERR_BIT = 26;
    localparam int MISPLACED_ERR_BIT = 27;
    localparam int CHECKSUM_ERR_BIT = 28;
    localparam int UNMAPPED_ERR_BIT = 29;
    localparam int IGNORE_MASTERS_BIT = 16;
    localparam int SKIP_CHECKSUM_BIT = 17;
    localparam logic [6:0] EXPANDER_ADDR_RESET = 7'h00;
    localparam logic [4:0] ARB_LIMIT = 5'h10;
    localparam logic [31:0] STATUS_RW1C_MASK = 32'h3e000000;
endpackage : smbus_status_pkg

// ---- core/arb_event_if.sv ----
`timescale 1ns/1ps
interface arb_event_if;
    logic arb_lost;
    logic arb_won;
    logic xact_start;
    logic ignore_masters;
    logic retry;
    logic abort;
    modport counter (input arb_lost, input arb_won, input xact_start, input ignore_masters, output retry, output abort);
    modport user (output arb_lost, output arb_won, output xact_start, output ignore_masters, input retry, input abort);
endinterface : arb_event_if

// ---- core/arb_retry_counter.sv ----
`timescale 1ns/1ps
module arb_retry_counter
    import smbus_status_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    arb_event_if.counter ev
);
    typedef struct packed
    {
        logic [4:0] lost_cnt;
        logic retry;
        logic abort;
    } arb_state_t;

    arb_state_t st_r;
    arb_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.retry = 1'b0;
        st_nxt.abort = 1'b0;
        if (!rst_n || ev.xact_start || ev.arb_won)
        begin
            st_nxt.lost_cnt = 5'h00;
        end
        else if (ev.arb_lost && !ev.ignore_masters)
        begin
            if (st_r.lost_cnt + 5'h01 == ARB_LIMIT)
            begin
                st_nxt.abort = 1'b1;
                st_nxt.lost_cnt = 5'h00;
            end
            else
            begin
                st_nxt.retry = 1'b1;
                st_nxt.lost_cnt = st_r.lost_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        st_r <= st_nxt;
    end

    assign ev.retry = st_r.retry;
    assign ev.abort = st_r.abort;

    property p_no_abort_ignoring;
        @(posedge mclk) disable iff (!rst_n)
        ev.ignore_masters && $past(ev.ignore_masters) |-> !ev.abort;
    endproperty
    a_no_abort_ignoring: assert property (p_no_abort_ignoring) else $error("abort while ignoring rivals");

    property p_retry_on_loss;
        @(posedge mclk) disable iff (!rst_n)
        ev.arb_lost && !ev.ignore_masters && !ev.xact_start && !ev.arb_won |=> ev.retry || ev.abort;
    endproperty
    a_retry_on_loss: assert property (p_retry_on_loss) else $error("lost arbitration not retried");
endmodule : arb_retry_counter

// ---- tb/smbus_target_model.sv ----
`timescale 1ns/1ps
// Far side event sources: loader and master port, one pulse per go
module smbus_target_model (
    input wire logic [3:0] ev_code,
    input wire logic ev_go,
    output logic nack_seen,
    output logic misplaced_cond,
    output logic unmapped_load_write,
    output logic no_config_done,
    output logic checksum_mismatch,
    output logic load_finished,
    output logic load_error_stop,
    output logic arb_lost,
    output logic xact_start,
    output logic arb_won
);
    assign nack_seen = ev_go && ev_code == 4'h0;
    assign misplaced_cond = ev_go && ev_code == 4'h1;
    assign unmapped_load_write = ev_go && ev_code == 4'h2;
    assign no_config_done = ev_go && ev_code == 4'h3;
    assign checksum_mismatch = ev_go && ev_code == 4'h4;
    assign load_finished = ev_go && ev_code == 4'h5;
    assign load_error_stop = ev_go && ev_code == 4'h6;
    assign arb_lost = ev_go && ev_code == 4'h7;
    assign xact_start = ev_go && ev_code == 4'h8;
    assign arb_won = ev_go && ev_code == 4'h9;
endmodule : smbus_target_model

// ---- tb/test_smbus_status_errors.sv ----
`timescale 1ns/1ps
module test_smbus_status_errors;
    import smbus_status_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_unlocked = 1'b0;
    logic load_at_reset_mode = 1'b0;
    logic [6:0] slave_port_addr = 7'h00;
    logic [6:0] master_port_addr = 7'h00;
    logic [3:0] ev_code = 4'h0;
    logic ev_go = 1'b0;
    logic [31:0] reg_rdata;
    logic [6:0] expander_addr;
    logic nack_seen, misplaced_cond, unmapped_load_write, no_config_done, checksum_mismatch;
    logic load_finished, load_error_stop, arb_lost, xact_start, arb_won;
    logic arb_retry, xact_abort, skip_checksum_check, ignore_rival_masters;
    logic [31:0] st_m;
    logic [31:0] ctl_m;
    logic [31:0] rnd = 32'h8cc082de;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    smbus_target_model far (.ev_code(ev_code), .ev_go(ev_go), .nack_seen(nack_seen),
        .misplaced_cond(misplaced_cond), .unmapped_load_write(unmapped_load_write),
        .no_config_done(no_config_done), .checksum_mismatch(checksum_mismatch),
        .load_finished(load_finished), .load_error_stop(load_error_stop), .arb_lost(arb_lost),
        .xact_start(xact_start), .arb_won(arb_won));

    smbus_status_errors dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_unlocked(reg_unlocked),
        .slave_port_addr(slave_port_addr), .master_port_addr(master_port_addr),
        .load_at_reset_mode(load_at_reset_mode), .load_finished(load_finished),
        .load_error_stop(load_error_stop), .checksum_mismatch(checksum_mismatch),
        .no_config_done(no_config_done), .unmapped_load_write(unmapped_load_write),
        .nack_seen(nack_seen), .misplaced_cond(misplaced_cond), .xact_start(xact_start),
        .arb_won(arb_won), .arb_lost(arb_lost), .arb_retry(arb_retry), .xact_abort(xact_abort),
        .expander_addr(expander_addr), .skip_checksum_check(skip_checksum_check),
        .ignore_rival_masters(ignore_rival_masters));

    always #4 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction : xs

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            fails++;
            stop_test();
        end
    end

    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        if (a == STATUS_OFFSET)
        begin
            st_m = st_m & ~(d & STATUS_RW1C_MASK);
            if (reg_unlocked)
                st_m[23:17] = d[23:17];
        end
        if (a == CONTROL_OFFSET)
            ctl_m = d & 32'h00030000;
    endtask : reg_write

    task automatic reg_read(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(what, reg_rdata, exp);
    endtask : reg_read

    task automatic fire(input int c);
        @(posedge mclk);
        ev_code <= c[3:0];
        ev_go <= 1'b1;
        @(posedge mclk);
        ev_go <= 1'b0;
        case (c)
            0: st_m[NACK_ERR_BIT] = 1'b1;
            1: st_m[MISPLACED_ERR_BIT] = 1'b1;
            2: st_m[UNMAPPED_ERR_BIT] = 1'b1;
            3: st_m[CHECKSUM_ERR_BIT] = 1'b1;
            4: if (!ctl_m[SKIP_CHECKSUM_BIT]) st_m[CHECKSUM_ERR_BIT] = 1'b1;
            5, 6: if (load_at_reset_mode) st_m[LOAD_DONE_BIT] = 1'b1;
            default: ;
        endcase
    endtask : fire

    task automatic lose(input logic rt, input logic ab);
        fire(7);
        @(posedge mclk);
        #1 check("retry", {31'h0, arb_retry}, {31'h0, rt});
        check("abort", {31'h0, xact_abort}, {31'h0, ab});
        if (ab)
            st_m[LOST_ARB_ERR_BIT] = 1'b1;
    endtask : lose

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rnd = xs(rnd);
        slave_port_addr = rnd[6:0];
        rnd = xs(rnd);
        master_port_addr = rnd[6:0];
        st_m = {16'h0000, master_port_addr, 1'b0, slave_port_addr, 1'b0};
        ctl_m = 32'h0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        reg_read(STATUS_OFFSET, st_m, "status reset");
        reg_read(CONTROL_OFFSET, ctl_m, "control reset");
        reg_read(12'h0a8, 32'h0, "unmapped read");
        // Expander locked, then unlocked; reserved and done bits written as ones
        rnd = xs(rnd);
        reg_write(STATUS_OFFSET, {2'b11, 5'h00, 1'b1, rnd[6:0], 17'h10101});
        reg_read(STATUS_OFFSET, st_m, "locked write");
        @(posedge mclk);
        reg_unlocked <= 1'b1;
        reg_write(STATUS_OFFSET, {2'b11, 5'h00, 1'b1, rnd[6:0], 17'h10101});
        reg_read(STATUS_OFFSET, st_m, "unlocked write");
        check("expander", {25'h0, expander_addr}, {25'h0, st_m[23:17]});
        for (int c = 0; c < 5; c++)
        begin
            fire(c);
            reg_read(STATUS_OFFSET, st_m, "flag set");
        end
        for (int b = 25; b < 30; b++)
        begin
            reg_write(STATUS_OFFSET, (32'h1 << b) | {8'h00, st_m[23:17], 17'h0});
            reg_read(STATUS_OFFSET, st_m, "flag clear");
        end
        reg_write(CONTROL_OFFSET, 32'h00020000);
        #1 check("skip out", {31'h0, skip_checksum_check}, {31'h0, ctl_m[SKIP_CHECKSUM_BIT]});
        reg_read(CONTROL_OFFSET, ctl_m, "control skip");
        fire(4);
        reg_read(STATUS_OFFSET, st_m, "checksum skipped");
        fire(3);
        reg_read(STATUS_OFFSET, st_m, "missing done cmd");
        fire(5);
        reg_read(STATUS_OFFSET, st_m, "done mode off");
        @(posedge mclk);
        load_at_reset_mode <= 1'b1;
        fire(6);
        fire(5);
        reg_write(STATUS_OFFSET, 32'h11000000 | {8'h00, st_m[23:17], 17'h0});
        reg_read(STATUS_OFFSET, st_m, "done sticky");
        reg_write(CONTROL_OFFSET, 32'h0);
        for (int i = 1; i <= 10; i++)
            lose(1'b1, 1'b0);
        fire(8);
        for (int i = 1; i <= 15; i++)
            lose(1'b1, 1'b0);
        fire(9);
        for (int i = 1; i <= 16; i++)
            lose(i < 16, i == 16);
        reg_read(STATUS_OFFSET, st_m, "lost arb flag");
        reg_write(CONTROL_OFFSET, 32'h00010000);
        #1 check("ignore out", {31'h0, ignore_rival_masters}, {31'h0, ctl_m[IGNORE_MASTERS_BIT]});
        reg_read(CONTROL_OFFSET, ctl_m, "control ignore");
        for (int i = 1; i <= 17; i++)
            lose(1'b0, 1'b0);
        reg_write(STATUS_OFFSET, 32'h04000000 | {8'h00, st_m[23:17], 17'h0});
        reg_read(STATUS_OFFSET, st_m, "lost arb clear");
        stop_test();
    end
endmodule : test_smbus_status_errors
